// ### src/pot_register_page_access.v
// Two-wire slave access to wiper and stored-level registers of a dual pot
`timescale 1ns/1ns
`include "pot_regs.vh"
module pot_register_page_access
#(
	parameter [`TIMER_WIDTH-1:0] NV_WRITE_CYCLES =
		`NV_CYCLES_DEF
)
(
	input  wire       CLK_I,
	input  wire       RST_I,
	input  wire       SCL_I,
	input  wire       SDA_I,
	output wire       SDA_O,
	output wire       SDA_OE_N_O,
	input  wire       WP_N_I,
	input  wire [2:0] HW_ADDR_I,
	output wire [7:0] POT_ZERO_WIPER_A_O,
	output wire [7:0] POT_ONE_WIPER_B_O,
	output wire [7:0] POT_ONE_WIPER_A_O,
	output wire [7:0] POT_ZERO_WIPER_B_O,
	output wire       NV_BUSY_O
);

	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam [2:0] S_IDLE    = 3'h0;
	localparam [2:0] S_DEVADDR = 3'h1;
	localparam [2:0] S_REGADDR = 3'h2;
	localparam [2:0] S_WDATA   = 3'h3;
	localparam [2:0] S_RDATA   = 3'h4;
	localparam [2:0] S_MACK    = 3'h5;

	reg  [2:0] state;
	reg  [3:0] bit_cnt;
	reg  [7:0] shreg;
	reg        in_ack;
	reg        sda_low;
	reg  [7:0] reg_addr;
	reg  [1:0] ptr;
	reg  [2:0] selection_reg;
	reg  [7:0] page_buf [0:3];
	reg  [3:0] page_valid;
	reg        recall;
	reg  [7:0] stored_level_reg [0:15];
	reg  [7:0] wiper_position_reg [0:3];
	reg        nv_launch;
	integer    i;

	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	wire       busy;
	wire       nonvolatile_select;
	wire [1:0] level;
	wire [7:0] read_byte;
	wire [7:0] rx_byte;

	// ------------------------------------------------------------------
	// Line conditions and busy timer
	// ------------------------------------------------------------------
	bus_cond_detect u_cond
	(
		.clk_i      (CLK_I),
		.rst_i      (RST_I),
		.scl_i      (SCL_I),
		.sda_i      (SDA_I),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_det),
		.stop_o     (stop_det)
	);

	nv_write_timer #(.CYCLES(NV_WRITE_CYCLES)) u_timer
	(
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.start_i (nv_launch),
		.busy_o  (busy)
	);

	// ------------------------------------------------------------------
	// Selection decode and read data choice
	// ------------------------------------------------------------------
	assign nonvolatile_select = selection_reg[`SEL_NV_BIT];
	assign level              = selection_reg[`SEL_LVL_HI:`SEL_LVL_LO];
	assign rx_byte            = shreg;
	// The selection register reads back with the upper bits at zero
	assign read_byte = (reg_addr == `ADDR_SEL) ? {`SEL_PAD, selection_reg} :
		nonvolatile_select ? stored_level_reg[{level, ptr}] :
		wiper_position_reg[ptr];

	// Open-drain data line: only ever pulled low, never driven high
	assign SDA_O      = `SDA_LOW_LEVEL;
	assign SDA_OE_N_O = ~sda_low;
	assign NV_BUSY_O  = busy;

	// Address order inside a page equals the wiper order 0A, 1B, 1A, 0B
	assign POT_ZERO_WIPER_A_O = wiper_position_reg[0];
	assign POT_ONE_WIPER_B_O  = wiper_position_reg[1];
	assign POT_ONE_WIPER_A_O  = wiper_position_reg[2];
	assign POT_ZERO_WIPER_B_O = wiper_position_reg[3];

	// ------------------------------------------------------------------
	// Protocol engine and register updates
	// ------------------------------------------------------------------
	// One process owns all register state so that a row copy and a single
	// byte write in the same cycle resolve by statement order: byte last.
	always @(posedge CLK_I)
	begin
		nv_launch <= 1'b0;
		if (RST_I)
		begin
			state         <= S_IDLE;
			bit_cnt       <= `CNT_ZERO;
			shreg         <= `WIPER_RESET;
			in_ack        <= 1'b0;
			sda_low       <= 1'b0;
			reg_addr      <= `WIPER_RESET;
			ptr           <= `PTR_RESET;
			selection_reg <= `SEL_RESET;
			page_valid    <= `VALID_NONE;
			recall        <= 1'b1;
			nv_launch     <= 1'b0;
			for (i = 0; i < `NV_REG_COUNT; i = i + 1)
				stored_level_reg[i] <= `NV_INIT;
			for (i = 0; i < `PAGE_SIZE; i = i + 1)
			begin
				wiper_position_reg[i] <= `WIPER_RESET;
				page_buf[i]           <= `WIPER_RESET;
			end
		end
		else if (recall)
		begin
			// Power-on recall of level 0 into the wipers
			recall <= 1'b0;
			for (i = 0; i < `PAGE_SIZE; i = i + 1)
				wiper_position_reg[i] <= stored_level_reg[{`LVL_POWERUP, i[1:0]}];
		end
		else if (busy)
		begin
			// Line released, every bus event ignored
			state   <= S_IDLE;
			sda_low <= 1'b0;
		end
		else if (stop_det)
		begin
			state   <= S_IDLE;
			sda_low <= 1'b0;
			in_ack  <= 1'b0;
			if (page_valid != `VALID_NONE)
			begin
				page_valid <= `VALID_NONE;
				if (WP_N_I)
				begin
					nv_launch <= 1'b1;
					for (i = 0; i < `PAGE_SIZE; i = i + 1)
					begin
						if (page_valid[i])
							stored_level_reg[{level, i[1:0]}] <= page_buf[i];
						else
							wiper_position_reg[i] <= stored_level_reg[{level, i[1:0]}];
					end
				end
				// Protect low: buffered bytes simply dropped
			end
		end
		else if (start_det)
		begin
			// Also a repeated start in the middle of a transfer
			state   <= S_DEVADDR;
			bit_cnt <= `CNT_ZERO;
			in_ack  <= 1'b0;
			sda_low <= 1'b0;
		end
		else
		begin
			case (state)
				S_DEVADDR, S_REGADDR, S_WDATA:
				begin
					if (scl_rise && !in_ack && bit_cnt != `BYTE_BITS)
					begin
						shreg   <= {shreg[6:0], SDA_I};
						bit_cnt <= bit_cnt + `CNT_ONE;
					end
					else if (scl_fall && in_ack)
					begin
						in_ack  <= 1'b0;
						sda_low <= 1'b0;
						if (state == S_RDATA)
							state <= S_RDATA;
					end
					else if (scl_fall && bit_cnt == `BYTE_BITS)
					begin
						bit_cnt <= `CNT_ZERO;
						in_ack  <= 1'b1;
						sda_low <= 1'b1;
						if (state == S_DEVADDR)
						begin
							if (rx_byte[7:1] != {`DEV_TYPE, HW_ADDR_I})
							begin
								state   <= S_IDLE;
								in_ack  <= 1'b0;
								sda_low <= 1'b0;
							end
							else if (rx_byte[0])
								state <= S_RDATA;
							else
								state <= S_REGADDR;
						end
						else if (state == S_REGADDR)
						begin
							state    <= S_WDATA;
							reg_addr <= rx_byte;
							if (rx_byte < `ADDR_WIPER_LIMIT)
								ptr <= rx_byte[1:0];
						end
						else if (reg_addr == `ADDR_SEL)
						begin
							selection_reg <= rx_byte[2:0];
							// Choosing a stored level pulls its row into the wipers
							if (rx_byte[`SEL_NV_BIT])
								for (i = 0; i < `PAGE_SIZE; i = i + 1)
									wiper_position_reg[i] <=
										stored_level_reg[{rx_byte[`SEL_LVL_HI:`SEL_LVL_LO], i[1:0]}];
						end
						else if (reg_addr < `ADDR_WIPER_LIMIT)
						begin
							wiper_position_reg[ptr] <= rx_byte;
							if (nonvolatile_select)
							begin
								page_buf[ptr]   <= rx_byte;
								page_valid[ptr] <= 1'b1;
							end
							ptr <= ptr + `PTR_STEP;
						end
					end
				end
				S_RDATA:
				begin
					if (scl_fall)
					begin
						in_ack <= 1'b0;
						if (bit_cnt == `CNT_ZERO)
						begin
							shreg   <= {read_byte[6:0], 1'b0};
							sda_low <= ~read_byte[7];
							bit_cnt <= `CNT_ONE;
							ptr     <= ptr + `PTR_STEP;
							if (nonvolatile_select && reg_addr != `ADDR_SEL)
								for (i = 0; i < `PAGE_SIZE; i = i + 1)
									wiper_position_reg[i] <=
										stored_level_reg[{level, i[1:0]}];
						end
						else if (bit_cnt != `BYTE_BITS)
						begin
							shreg   <= {shreg[6:0], 1'b0};
							sda_low <= ~shreg[7];
							bit_cnt <= bit_cnt + `CNT_ONE;
						end
						else
						begin
							// Release for the master's acknowledge slot
							sda_low <= 1'b0;
							bit_cnt <= `CNT_ZERO;
							state   <= S_MACK;
						end
					end
				end
				S_MACK:
				begin
					if (scl_rise)
						state <= SDA_I ? S_IDLE : S_RDATA;
				end
				default:
				begin
					sda_low <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ### src/pot_regs.vh
// Constants for the two-wire wiper and stored-level register access block
`ifndef POT_REGS_VH
`define POT_REGS_VH

// ----------------------------------------------------------------------
// Slave addressing and address byte
// ----------------------------------------------------------------------
`define DEV_TYPE         4'h5
`define ADDR_SEL         8'h07
`define ADDR_WIPER_LIMIT 8'h04

// ----------------------------------------------------------------------
// Selection register layout and reset values
// ----------------------------------------------------------------------
`define SEL_RESET        3'h0
`define SEL_NV_BIT       0
`define SEL_LVL_LO       1
`define SEL_LVL_HI       2
`define SEL_PAD          5'h00
`define PTR_RESET        2'h0
`define PTR_STEP         2'h1
`define LVL_POWERUP      2'h0
`define NV_INIT          8'h00
`define WIPER_RESET      8'h00
`define PAGE_SIZE        4
`define NV_REG_COUNT     16
`define VALID_NONE       4'h0

// ----------------------------------------------------------------------
// Bit counting on the serial line
// ----------------------------------------------------------------------
`define CNT_ZERO         4'h0
`define CNT_ONE          4'h1
`define BYTE_BITS        4'h8
`define SDA_LOW_LEVEL    1'b0

// ----------------------------------------------------------------------
// Nonvolatile write busy period
// ----------------------------------------------------------------------
// Busy period of 5 ms at 125 MHz; simulation shortens it by parameter
`define NV_CYCLES_DEF    24'h098968
`define TIMER_WIDTH      24
`define TIMER_ZERO       24'h000000
`define TIMER_ONE        24'h000001

`endif

// ### src/bus_cond_detect.v
// Edge and START/STOP detection for the two-wire bus lines
`timescale 1ns/1ns
module bus_cond_detect
(
	input  wire clk_i,
	input  wire rst_i,
	input  wire scl_i,
	input  wire sda_i,
	output wire scl_rise_o,
	output wire scl_fall_o,
	output wire start_o,
	output wire stop_o
);

	reg scl_q;
	reg sda_q;

	// ------------------------------------------------------------------
	// Previous line levels; idle bus is high, so reset to one
	// ------------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Data moving while the clock is high marks a bus condition
	assign scl_rise_o = scl_i & ~scl_q;
	assign scl_fall_o = ~scl_i & scl_q;
	assign start_o    = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_o     = scl_i & scl_q & ~sda_q & sda_i;

endmodule

// ### src/nv_write_timer.v
// Busy timer for the nonvolatile write cycle
`timescale 1ns/1ns
`include "pot_regs.vh"
module nv_write_timer
#(
	parameter [`TIMER_WIDTH-1:0] CYCLES = `TIMER_ONE
)
(
	input  wire clk_i,
	input  wire rst_i,
	input  wire start_i,
	output wire busy_o
);

	reg [`TIMER_WIDTH-1:0] count;

	// ------------------------------------------------------------------
	// Load on launch, count down to zero; busy while nonzero
	// ------------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
			count <= `TIMER_ZERO;
		else if (start_i)
			count <= CYCLES;
		else if (count != `TIMER_ZERO)
			count <= count - `TIMER_ONE;
	end

	assign busy_o = (count != `TIMER_ZERO);

endmodule

// ### verif/pot_access_chk.sv
// Port-level checker for the two-wire register page access block
`timescale 1ns/1ns
`include "pot_regs.vh"
module pot_access_chk
#(
	parameter [`TIMER_WIDTH-1:0] NV_WRITE_CYCLES = `TIMER_ONE
)
(
	input  wire       CLK_I,
	input  wire       RST_I,
	input  wire       SCL_I,
	input  wire       SDA_I,
	input  wire       SDA_O,
	input  wire       SDA_OE_N_O,
	input  wire       WP_N_I,
	input  wire [2:0] HW_ADDR_I,
	input  wire [7:0] POT_ZERO_WIPER_A_O,
	input  wire [7:0] POT_ONE_WIPER_B_O,
	input  wire [7:0] POT_ONE_WIPER_A_O,
	input  wire [7:0] POT_ZERO_WIPER_B_O,
	input  wire       NV_BUSY_O
);
	// ------------------------------------------------------------
	// Busy period length and wiper watch
	// ------------------------------------------------------------
	reg  [`TIMER_WIDTH-1:0] busy_len;
	wire [31:0]             wipers;
	assign wipers = {POT_ZERO_WIPER_A_O, POT_ONE_WIPER_B_O, POT_ONE_WIPER_A_O,
		POT_ZERO_WIPER_B_O};
	// Cleared while idle so each busy period is measured on its own
	always @(posedge CLK_I)
	begin
		if (RST_I || !NV_BUSY_O)
			busy_len <= `TIMER_ZERO;
		else
			busy_len <= busy_len + `TIMER_ONE;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	busy_wp_a: assert property ($rose(NV_BUSY_O) |-> $past(WP_N_I))
		else $error("busy started with write protect low");
	busy_stop_a: assert property ($rose(NV_BUSY_O) |-> $past(SCL_I) && $past(SDA_I))
		else $error("busy started without a stop");
	busy_len_a: assert property ($fell(NV_BUSY_O) |-> busy_len == NV_WRITE_CYCLES)
		else $error("busy period has wrong length");
	busy_quiet_a: assert property (NV_BUSY_O |-> SDA_OE_N_O)
		else $error("data line driven while busy");
	wiper_busy_a: assert property (NV_BUSY_O && $past(NV_BUSY_O) |-> $stable(wipers))
		else $error("wiper changed while busy");
	// A stop may reload unwritten wipers, and the stored write then follows
	wiper_scl_a: assert property ($changed(wipers)
		|-> ((!SCL_I) or (##1 NV_BUSY_O)))
		else $error("wiper changed with bus clock high");
	sda_hold_a: assert property (SCL_I && $past(SCL_I) && $past(SCL_I, 2)
		|-> $stable(SDA_OE_N_O))
		else $error("data drive changed with bus clock high");
	drive_low_a: assert property (!SDA_OE_N_O |-> SDA_O == `SDA_LOW_LEVEL)
		else $error("driven data level not low");
	drive_edge_a: assert property ($changed(SDA_OE_N_O) |-> !$past(SCL_I))
		else $error("data drive changed after bus clock high");
	busy_cov: cover property ($rose(NV_BUSY_O));
	ack_cov: cover property ($fell(SDA_OE_N_O));
	wiper_cov: cover property ($changed(wipers));
endmodule
bind pot_register_page_access pot_access_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
	u_pot_access_chk (.CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
	.SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .WP_N_I(WP_N_I), .HW_ADDR_I(HW_ADDR_I),
	.POT_ZERO_WIPER_A_O(POT_ZERO_WIPER_A_O), .POT_ONE_WIPER_B_O(POT_ONE_WIPER_B_O),
	.POT_ONE_WIPER_A_O(POT_ONE_WIPER_A_O), .POT_ZERO_WIPER_B_O(POT_ZERO_WIPER_B_O),
	.NV_BUSY_O(NV_BUSY_O));

// ### verif/twi_master_model.sv
// Two-wire bus master model that drives clock and data of the slave
`timescale 1ns/1ns
module twi_master_model
(
	input  wire clk_i,
	input  wire sda_i,
	output reg  scl_o,
	output reg  sda_o
);
	// Both lines released at start; the pull-up holds them high
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// One third of a bus clock period
	task wt;
		repeat (4) @(posedge clk_i);
	endtask
	// Data moves only while the bus clock is low, so no false start or stop
	task bitx(input b, output r);
	begin
		wt;
		sda_o <= b;
		wt;
		scl_o <= 1'b1;
		wt;
		r = sda_i;
		scl_o <= 1'b0;
	end
	endtask
	// Start or repeated start: data falls with clock high
	task start;
	begin
		wt;
		sda_o <= 1'b1;
		wt;
		scl_o <= 1'b1;
		wt;
		sda_o <= 1'b0;
		wt;
		scl_o <= 1'b0;
	end
	endtask
	// Stop: data rises with clock high
	task stop;
	begin
		wt;
		sda_o <= 1'b0;
		wt;
		scl_o <= 1'b1;
		wt;
		sda_o <= 1'b1;
		wt;
	end
	endtask
	// Byte out MSB first, then sample the slave's acknowledge
	task wr(input [7:0] d, output ack);
		reg     r;
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	end
	endtask
	// Byte in MSB first; acknowledge asks for one more byte
	task rd(input more, output [7:0] d);
		reg     r;
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(~more, r);
	end
	endtask
endmodule

// ### verif/pot_register_page_access_tb.sv
// Self-checking bench for the two-wire register page access block
`timescale 1ns/1ns
`include "pot_regs.vh"
module pot_register_page_access_tb;
	// ------------------------------------------------------------
	// Bench signals, design and master
	// ------------------------------------------------------------
	localparam [23:0] NVC = 24'h000190; // Short busy period, still longer than one byte
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         wp_n = 1'b1;
	reg  [2:0]  hw = 3'h5;
	wire        scl, sda_m, sda_d, sda_oe_n, busy;
	wire [7:0]  w0a, w1b, w1a, w0b;
	wire        sda = sda_m & (sda_oe_n | sda_d); // Pull-up with open-drain parties
	integer     bad_count = 0;
	integer     n_tests = 0;
	integer     i;
	always #4 clk = ~clk;
	pot_register_page_access #(.NV_WRITE_CYCLES(NVC)) u_pot_register_page_access (
		.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_d),
		.SDA_OE_N_O(sda_oe_n), .WP_N_I(wp_n), .HW_ADDR_I(hw),
		.POT_ZERO_WIPER_A_O(w0a), .POT_ONE_WIPER_B_O(w1b), .POT_ONE_WIPER_A_O(w1a),
		.POT_ZERO_WIPER_B_O(w0b), .NV_BUSY_O(busy));
	twi_master_model u_twi_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_o(sda_m));
	// Compare and count
	task check(input string nm, input [7:0] seen, input [7:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// Byte with expected acknowledge
	task wb(input [7:0] d, input string nm);
		reg a;
	begin
		u_twi_master_model.wr(d, a);
		check(nm, {7'h00, a}, 8'h01);
	end
	endtask
	task setp(input [7:0] adr);
	begin
		u_twi_master_model.start;
		wb({`DEV_TYPE, hw, 1'b0}, "slave ack");
		wb(adr, "addr ack"); // Unused address bits zero
	end
	endtask
	// Page write of n bytes taken from the top of d
	task wr(input [7:0] adr, input integer n, input [39:0] d);
	begin
		setp(adr);
		for (i = 0; i < n; i = i + 1)
			wb(d[39 - 8 * i -: 8], "data ack");
		u_twi_master_model.stop;
	end
	endtask
	// Random read of n bytes, each compared with the top of e
	task rd(input [7:0] adr, input integer n, input [31:0] e);
		reg [7:0] d;
		integer   k;
	begin
		setp(adr);
		u_twi_master_model.start;
		wb({`DEV_TYPE, hw, 1'b1}, "read slave ack");
		for (k = 0; k < n; k = k + 1)
		begin
			u_twi_master_model.rd(k < n - 1, d);
			check("read data", d, e[31 - 8 * k -: 8]);
		end
		u_twi_master_model.stop;
	end
	endtask
	task wip(input [31:0] e);
	begin
		check("wiper 0a", w0a, e[31:24]);
		check("wiper 1b", w1b, e[23:16]);
		check("wiper 1a", w1a, e[15:8]);
		check("wiper 0b", w0b, e[7:0]);
	end
	endtask
	// Reset values of wipers, busy and selection
	task t_reset;
		reg a;
	begin
		wip(32'h00000000);
		// Another hardware address must go unanswered
		u_twi_master_model.start;
		u_twi_master_model.wr({`DEV_TYPE, hw ^ 3'h1, 1'b0}, a);
		check("foreign ack", {7'h00, a}, 8'h00);
		u_twi_master_model.stop;
		check("busy", {7'h00, busy}, 8'h00);
		rd(`ADDR_SEL, 1, 32'h00000000);
	end
	endtask
	// Volatile page of five bytes wraps and overwrites; read wraps 0B to 0A
	task t_vol;
	begin
		wr(8'h02, 5, 40'h1122334455);
		wip(32'h33445522);
		check("busy", {7'h00, busy}, 8'h00);
		rd(8'h01, 4, 32'h44552233);
	end
	endtask
	// Stored level page write, busy refusal, then read back
	task t_nv;
		reg a;
	begin
		wr(`ADDR_SEL, 1, 40'h0300000000);
		rd(`ADDR_SEL, 1, 32'h03000000);
		wr(8'h02, 3, 40'hA1A2A30000);
		check("busy", {7'h00, busy}, 8'h01);
		wip(32'hA300A1A2);
		u_twi_master_model.start;
		u_twi_master_model.wr({`DEV_TYPE, hw, 1'b0}, a);
		check("busy ack", {7'h00, a}, 8'h00);
		u_twi_master_model.stop;
		for (i = 0; i < 1000 && busy === 1'b1; i = i + 1)
			@(posedge clk);
		check("busy end", {7'h00, busy}, 8'h00);
		rd(8'h00, 4, 32'hA300A1A2);
	end
	endtask
	// Write protect discards the page; read restores the whole row
	task t_wp;
	begin
		wp_n <= 1'b0;
		wr(8'h01, 1, 40'h5A00000000);
		wip(32'hA35AA1A2);
		check("busy", {7'h00, busy}, 8'h00);
		wp_n <= 1'b1;
		rd(8'h01, 1, 32'h00000000);
		wip(32'hA300A1A2);
	end
	endtask
	// Main sequence after a 12 cycle reset
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset;
		t_vol;
		t_nv;
		t_wp;
		end_of_test;
	end
	// Watchdog well beyond the expected run of about 45 us
	initial
	begin
		#400000;
		bad_count = bad_count + 1;
		end_of_test;
	end
endmodule
